/* File: design/external_pin_interrupt_unit.v */
// Summary of operation
// - pin one sense: low, change, fall, rise
// - pin zero sense uses same encoding
// - sample pin before edges; >1 clock caught
// - pin one needs global and own enable
// - pin two edge only; polarity bit six
// - pin two edges captured without clock
// - enable bits seven, six, five with global
// - pin activity counts even when driven output
// - each input has its own request vector
// - flags at bits seven, six, five; rest zero
// - flag clears on vector service or one
// - low-level inputs keep flag at zero
// - buffer shut in sleep may set pin two
// - level wake-up and pin two detection work asynchronously
// - level taken from second sample stage alone, no agreement check
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps

module external_pin_interrupt_unit
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // avalon-mm slave
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // pins and system
    input  wire        ext_pin_zero,
    input  wire        ext_pin_one,
    input  wire        ext_pin_two,
    input  wire        sleep_deep,
    input  wire [2:0]  vector_ack,
    output wire [2:0]  vector_req,
    output wire        irq,
    output wire        wake_request,
    output wire        debug_port_disable
);

`include "ext_irq_consts.vh"

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [7:0] sense_control;
    reg  [7:0] control_status;
    reg  [7:0] irq_enable;
    reg        pin0_flag;
    reg        pin1_flag;
    reg        pin2_flag;
    reg  [7:0] processor_status_word;
    reg        bus_ack;
    reg  [7:0] next_readdata;

    wire       bus_req;
    wire       bus_done;
    wire       wr_byte0;
    wire [7:0] wbyte;
    wire       global_on;
    wire [1:0] pin0_sense;
    wire [1:0] pin1_sense;
    wire       pin2_polarity;
    wire       pin0_low_mode;
    wire       pin1_low_mode;

    assign pin0_sense    = {sense_control[`PIN0_SENSE_HI], sense_control[`PIN0_SENSE_LO]};
    assign pin1_sense    = {sense_control[`PIN1_SENSE_HI], sense_control[`PIN1_SENSE_LO]};
    assign pin2_polarity = control_status[`PIN2_POLARITY];
    assign pin0_low_mode = (pin0_sense == `SENSE_LOW);
    assign pin1_low_mode = (pin1_sense == `SENSE_LOW);
    assign global_on     = processor_status_word[`GLOBAL_IRQ_BIT];
    assign debug_port_disable = control_status[`DEBUG_PORT_DISABLE];

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // one wait state: readdata is registered in the first cycle,
    // and the access completes on the edge where waitrequest is low;
    // a low clock enable keeps waitrequest high so no write is dropped
    assign bus_req     = read | write;
    assign bus_done    = bus_req & bus_ack & ce;
    assign waitrequest = bus_req & ~bus_done;
    assign wr_byte0    = write & bus_done & byteenable[0];
    assign wbyte       = writedata[7:0];

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus_ack <= 1'b0;
        end
        else if (ce)
        begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // ----------------------------------------------------------------
    // pin zero and pin one detection
    // ----------------------------------------------------------------
    // the pin value is read regardless of port direction, so a
    // driven output still raises requests
    wire pin0_event;
    wire pin1_event;
    wire pin0_level_low;
    wire pin1_level_low;

    edge_sense u_sense0
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .pin       (ext_pin_zero),
        .sense     (pin0_sense),
        .event_hit (pin0_event),
        .level_low (pin0_level_low)
    );

    edge_sense u_sense1
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .pin       (ext_pin_one),
        .sense     (pin1_sense),
        .event_hit (pin1_event),
        .level_low (pin1_level_low)
    );

    // ----------------------------------------------------------------
    // pin two asynchronous capture
    // ----------------------------------------------------------------
    // the input buffer is shut in deep sleep when pin two is
    // disabled; the forced low may look like an edge
    wire pin2_buffered;
    wire pin2_edge_clk;
    reg  pin2_toggle;
    reg  pin2_sync_a;
    reg  pin2_sync_b;
    reg  pin2_seen;
    wire pin2_event;

    assign pin2_buffered = ext_pin_two & ~(sleep_deep & ~irq_enable[`EN_PIN2]);
    // polarity zero means falling edge
    // a polarity change can itself form an edge here, hence the
    // software ordering on the far side
    assign pin2_edge_clk = pin2_polarity ? pin2_buffered : ~pin2_buffered;

    // no clock needed; any pulse wider than the minimum width
    // flips the toggle
    always @(posedge pin2_edge_clk or posedge rst)
    begin
        if (rst)
        begin
            pin2_toggle <= 1'b0;
        end
        else
        begin
            pin2_toggle <= ~pin2_toggle;
        end
    end

    // toggle crossing into the system clock
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin2_sync_a <= 1'b0;
            pin2_sync_b <= 1'b0;
            pin2_seen   <= 1'b0;
        end
        else if (ce)
        begin
            pin2_sync_a <= pin2_toggle;
            pin2_sync_b <= pin2_sync_a;
            pin2_seen   <= pin2_sync_b;
        end
    end

    assign pin2_event = pin2_sync_b ^ pin2_seen;

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    wire clr0;
    wire clr1;
    wire clr2;
    wire flag_write;

    // one write-one-to-clear strobe shared by all three flags
    assign flag_write = wr_byte0 & (address == `OFS_IRQ_FLAGS);
    // cleared by servicing the vector or by writing one
    assign clr0 = vector_ack[0] | (flag_write & wbyte[`FLAG_PIN0]);
    assign clr1 = vector_ack[1] | (flag_write & wbyte[`FLAG_PIN1]);
    assign clr2 = vector_ack[2] | (flag_write & wbyte[`FLAG_PIN2]);

    // a new event beats a clear in the same cycle; low-level mode
    // overrides both so the flag is never seen set there
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin0_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (pin0_low_mode)
                pin0_flag <= 1'b0;
            else if (pin0_event)
                pin0_flag <= 1'b1;
            else if (clr0)
                pin0_flag <= 1'b0;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin1_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (pin1_low_mode)
                pin1_flag <= 1'b0;
            else if (pin1_event)
                pin1_flag <= 1'b1;
            else if (clr1)
                pin1_flag <= 1'b0;
        end
    end

    // pin two has no level mode, so only event and clear compete
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin2_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (pin2_event)
                pin2_flag <= 1'b1;
            else if (clr2)
                pin2_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sense_control         <= `RST_SENSE_CONTROL;
            control_status        <= `RST_CONTROL_STATUS;
            irq_enable            <= `RST_IRQ_ENABLE;
            processor_status_word <= `RST_PROC_STATUS;
        end
        else if (ce && wr_byte0)
        begin
            case (address)
                `OFS_SENSE_CONTROL:
                    sense_control <= wbyte;
                `OFS_CONTROL_STATUS:
                    control_status <= wbyte & `MASK_CONTROL_STATUS;
                `OFS_IRQ_ENABLE:
                    irq_enable <= wbyte & `MASK_IRQ_ENABLE;
                `OFS_PROC_STATUS:
                    processor_status_word <= wbyte & `MASK_PROC_STATUS;
                default:
                    sense_control <= sense_control;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always @*
    begin
        next_readdata = 8'h00;
        case (address)
            `OFS_SENSE_CONTROL:  next_readdata = sense_control;
            `OFS_CONTROL_STATUS: next_readdata = control_status;
            `OFS_IRQ_ENABLE:     next_readdata = irq_enable;
            // reserved low bits read zero
            `OFS_IRQ_FLAGS:      next_readdata = {pin1_flag, pin0_flag, pin2_flag, 5'h00};
            `OFS_PROC_STATUS:    next_readdata = processor_status_word;
            default:             next_readdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            readdata <= 32'h0000_0000;
        end
        else if (ce && read && !bus_ack)
        begin
            readdata <= {24'h00_0000, next_readdata};
        end
    end

    // ----------------------------------------------------------------
    // requests
    // ----------------------------------------------------------------
    // the live level is used in low mode, so a source that lets go
    // early simply loses its request
    wire src0;
    wire src1;

    assign src0 = pin0_low_mode ? pin0_level_low : pin0_flag;
    assign src1 = pin1_low_mode ? pin1_level_low : pin1_flag;

    // one line per vector
    assign vector_req[0] = global_on & irq_enable[`EN_PIN0] & src0;
    assign vector_req[1] = global_on & irq_enable[`EN_PIN1] & src1;
    assign vector_req[2] = global_on & irq_enable[`EN_PIN2] & pin2_flag;
    assign irq           = |vector_req;

    // ----------------------------------------------------------------
    // wake-up
    // ----------------------------------------------------------------
    // unclocked path so a halted clock can still be woken; it does not
    // wait for the global bit, which only gates the vector requests
    wire wake0;
    wire wake1;
    wire wake2;

    assign wake0 = irq_enable[`EN_PIN0] & pin0_low_mode & ~ext_pin_zero;
    assign wake1 = irq_enable[`EN_PIN1] & pin1_low_mode & ~ext_pin_one;
    // stays up until the system clock has caught the toggle
    assign wake2 = irq_enable[`EN_PIN2] & (pin2_toggle ^ pin2_seen);
    assign wake_request = wake0 | wake1 | wake2;

endmodule // external_pin_interrupt_unit

/* File: design/ext_irq_consts.vh */
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SENSE_CONTROL   5'h00
`define OFS_CONTROL_STATUS  5'h04
`define OFS_IRQ_ENABLE      5'h08
`define OFS_IRQ_FLAGS       5'h0c
`define OFS_PROC_STATUS     5'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIN1_SENSE_HI       3
`define PIN1_SENSE_LO       2
`define PIN0_SENSE_HI       1
`define PIN0_SENSE_LO       0
`define DEBUG_PORT_DISABLE  7
`define PIN2_POLARITY       6
`define EN_PIN1             7
`define EN_PIN0             6
`define EN_PIN2             5
`define FLAG_PIN1           7
`define FLAG_PIN0           6
`define FLAG_PIN2           5
`define GLOBAL_IRQ_BIT      7

// ----------------------------------------------------------------
// sense encodings
// ----------------------------------------------------------------
`define SENSE_LOW           2'h0
`define SENSE_CHANGE        2'h1
`define SENSE_FALL          2'h2
`define SENSE_RISE          2'h3

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_SENSE_CONTROL   8'h00
`define RST_CONTROL_STATUS  8'h00
`define RST_IRQ_ENABLE      8'h00
`define RST_IRQ_FLAGS       8'h00
`define RST_PROC_STATUS     8'h00
`define MASK_CONTROL_STATUS 8'hc0
`define MASK_IRQ_ENABLE     8'he0
`define MASK_PROC_STATUS    8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define PIN2_MIN_PULSE_NS   50
`define PIN2_MIN_PULSE_CYC  ((`PIN2_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: design/edge_sense.v */
`timescale 1ns/1ps

module edge_sense
(
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       ce,
    input  wire       pin,
    input  wire [1:0] sense,
    output reg        event_hit,
    output wire       level_low
);

`include "ext_irq_consts.vh"

    reg sync_a;
    reg sync_b;
    reg sample_prev;
    reg next_event;

    // ----------------------------------------------------------------
    // two-stage sampling, then compare successive samples
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync_a      <= 1'b1;
            sync_b      <= 1'b1;
            sample_prev <= 1'b1;
            event_hit   <= 1'b0;
        end
        else if (ce)
        begin
            sync_a      <= pin;
            sync_b      <= sync_a;
            sample_prev <= sync_b;
            event_hit   <= next_event;
        end
    end

    always @*
    begin
        next_event = 1'b0;
        case (sense)
            `SENSE_LOW:    next_event = 1'b0;
            `SENSE_CHANGE: next_event = sync_b ^ sample_prev;
            `SENSE_FALL:   next_event = sample_prev & ~sync_b;
            `SENSE_RISE:   next_event = ~sample_prev & sync_b;
            default:       next_event = 1'b0;
        endcase
    end

    // low level is the second sampling stage alone; samples are not compared
    assign level_low = ~sync_b;

endmodule // edge_sense

/* File: bench/ext_pin_source.sv */
`timescale 1ns/1ps

module ext_pin_source
(
    input  wire clk_sys,
    output reg  pin_zero,
    output reg  pin_one,
    output reg  pin_two
);
// ----------------
// pin drivers
// ----------------
// idle high, as pulled-up lines
initial
begin
    pin_zero = 1'b1;
    pin_one = 1'b1;
    pin_two = 1'b1;
end

// a level stands until the next call, so a low level outlasts any instruction
task automatic drive(input int idx, input logic v);
    @(posedge clk_sys);
    case (idx)
        0: pin_zero <= v;
        1: pin_one <= v;
        default: pin_two <= v;
    endcase
endtask

// held whole cycles; callers keep pin two above the minimum width
task automatic pulse(input int idx, input logic v, input int cyc);
    drive(idx, v);
    repeat (cyc - 1) @(posedge clk_sys);
    drive(idx, !v);
endtask
endmodule // ext_pin_source

/* File: bench/ext_irq_monitor.sv */
`timescale 1ns/1ps
`include "ext_irq_consts.vh"

module ext_irq_monitor
(
    input wire        clk_sys,
    input wire        rst,
    input wire [4:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire        waitrequest,
    input wire        ext_pin_zero,
    input wire        ext_pin_one,
    input wire        ext_pin_two,
    input wire [2:0]  vector_req,
    input wire        irq,
    input wire        debug_port_disable
);
// ----------------
// register shadows, loaded where a write completes
// ----------------
reg  [7:0] sense;
reg  [7:0] cs;
reg  [7:0] en_reg;
reg        glob;
wire       take = write && !waitrequest && byteenable[0];
wire [2:0] en   = {en_reg[5], en_reg[7], en_reg[6]} & {3{glob}};

always @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        sense <= 8'h00;
        cs <= 8'h00;
        en_reg <= 8'h00;
        glob <= 1'b0;
    end
    else if (take)
    begin
        if (address == `OFS_SENSE_CONTROL) sense <= writedata[7:0];
        if (address == `OFS_CONTROL_STATUS) cs <= writedata[7:0];
        if (address == `OFS_IRQ_ENABLE) en_reg <= writedata[7:0];
        if (address == `OFS_PROC_STATUS) glob <= writedata[7];
    end
end

// ----------------
// properties
// ----------------
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (rst);

property p_one_wait;
    (read || write) && waitrequest |=> !waitrequest;
endproperty
a_one_wait: assert property (p_one_wait)
    else $error("bus wait longer than one cycle");
property p_irq_or;
    irq == |vector_req;
endproperty
a_irq_or: assert property (p_irq_or)
    else $error("irq differs from request OR");
property p_gate;
    (vector_req & ~en) == 3'h0;
endproperty
a_gate: assert property (p_gate)
    else $error("request without enable");
property p_level0;
    en[0] && sense[1:0] == `SENSE_LOW |-> vector_req[0] == !$past(ext_pin_zero, 2);
endproperty
a_level0: assert property (p_level0)
    else $error("low level request wrong");
property p_fall0;
    $fell(ext_pin_zero) && en[0] && sense[1:0] == `SENSE_FALL
        |-> ##4 (vector_req[0] || !en[0] || sense[1:0] != `SENSE_FALL);
endproperty
a_fall0: assert property (p_fall0)
    else $error("pin zero fall missed");
property p_rise1;
    $rose(ext_pin_one) && en[1] && sense[3:2] == `SENSE_RISE
        |-> ##4 (vector_req[1] || !en[1] || sense[3:2] != `SENSE_RISE);
endproperty
a_rise1: assert property (p_rise1)
    else $error("pin one rise missed");
property p_pin2;
    en[2] && (cs[6] ? $rose(ext_pin_two) : $fell(ext_pin_two)) |-> ##[2:4] (vector_req[2] || !en[2]);
endproperty
a_pin2: assert property (p_pin2)
    else $error("pin two edge missed");
property p_dbg;
    debug_port_disable == cs[7];
endproperty
a_dbg: assert property (p_dbg)
    else $error("debug disable differs from register");

c_pin2: cover property ($rose(vector_req[2]));
c_lvl: cover property (en[0] && sense[1:0] == `SENSE_LOW && vector_req[0]);
c_mask: cover property ($fell(irq));
endmodule // ext_irq_monitor

bind external_pin_interrupt_unit ext_irq_monitor ext_irq_monitor_inst
(
    .clk_sys, .rst, .address, .read, .write, .writedata, .byteenable, .waitrequest,
    .ext_pin_zero, .ext_pin_one, .ext_pin_two, .vector_req, .irq, .debug_port_disable
);

/* File: bench/external_pin_interrupt_unit_tb_top.sv */
`timescale 1ns/1ps
`include "ext_irq_consts.vh"

module external_pin_interrupt_unit_tb_top;
// ----------------
// signals and instances
// ----------------
logic        clk_sys, rst, ce, read, write, sleep_deep;
logic [4:0]  address;
logic [31:0] writedata;
logic [3:0]  byteenable;
logic [2:0]  vector_ack;
wire  [31:0] readdata;
wire  [2:0]  vector_req;
wire         waitrequest, ext_pin_zero, ext_pin_one, ext_pin_two, irq, debug_port_disable;
wire         wake_request;
int          n_errors = 0;
int          samples_checked = 0;
logic [7:0]  q;
logic [1:0]  s;
logic        p, f, t, ef, lv;
// pin, sense code, level before, level after, flag expected
logic [5:0]  rows [12] = '{6'b010101, 6'b010010, 6'b011011, 6'b001101, 6'b001011,
    6'b000100, 6'b111100, 6'b111011, 6'b110101, 6'b101011, 6'b100100, 6'b100010};

external_pin_interrupt_unit external_pin_interrupt_unit_inst
(
    .clk_sys, .rst, .ce, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .ext_pin_zero, .ext_pin_one, .ext_pin_two, .sleep_deep, .vector_ack,
    .vector_req, .irq, .wake_request, .debug_port_disable
);
ext_pin_source ext_pin_source_inst
(
    .clk_sys, .pin_zero(ext_pin_zero), .pin_one(ext_pin_one), .pin_two(ext_pin_two)
);

// ----------------
// tasks
// ----------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
        n_errors++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask

task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    // no limit of its own: the watchdog ends a hung wait
    do
    begin
        @(posedge clk_sys);
    end
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
endtask

task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
endtask

task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk({24'h0, q}, {24'h0, e});
endtask

// one edge lets the register update of the last write land first
task automatic reqchk(input logic [2:0] e);
    @(posedge clk_sys);
    chk({29'h0, vector_req}, {29'h0, e});
    chk({31'h0, irq}, {31'h0, |e});
endtask

task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

// ----------------
// clock, watchdog, sequence
// ----------------
initial
begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end

initial
begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
end

initial
begin
    rst = 1'b1;
    ce = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h1;
    sleep_deep = 1'b0;
    vector_ack = 3'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    wr(`OFS_PROC_STATUS, 8'h80);
    wr(`OFS_IRQ_ENABLE, 8'he0);
    foreach (rows[i])
    begin
        {p, s, f, t, ef} = rows[i];
        wr(`OFS_SENSE_CONTROL, p ? {4'h0, s, 2'h3} : {4'h0, 2'h3, s});
        ext_pin_source_inst.drive(p, f);
        repeat (8) @(posedge clk_sys);
        wr(`OFS_IRQ_FLAGS, 8'he0);
        ext_pin_source_inst.drive(p, t);
        repeat (8) @(posedge clk_sys);
        rdc(`OFS_IRQ_FLAGS, {p & ef, !p & ef, 6'h00});
        lv = (s == 2'h0) && !t;
        reqchk({1'b0, p & (ef | lv), !p & (ef | lv)});
        chk({31'h0, wake_request}, {31'h0, lv});
        ext_pin_source_inst.drive(p, 1'b1);
    end
    wr(`OFS_SENSE_CONTROL, 8'h0b);
    wr(`OFS_IRQ_FLAGS, 8'he0);
    ext_pin_source_inst.pulse(1, 1'b0, 2);
    repeat (8) @(posedge clk_sys);
    rdc(`OFS_IRQ_FLAGS, 8'h80);
    wr(`OFS_IRQ_ENABLE, 8'h60);
    reqchk(3'h0);
    wr(`OFS_IRQ_ENABLE, 8'he0);
    wr(`OFS_PROC_STATUS, 8'h00);
    reqchk(3'h0);
    wr(`OFS_PROC_STATUS, 8'h80);
    reqchk(3'h2);
    vector_ack <= 3'h2;
    @(posedge clk_sys);
    vector_ack <= 3'h0;
    rdc(`OFS_IRQ_FLAGS, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
        wr(`OFS_IRQ_ENABLE, 8'hc0);
        wr(`OFS_CONTROL_STATUS, k ? 8'h00 : 8'h40);
        // a polarity flip can set the flag a few edges late; clear after it lands
        repeat (4) @(posedge clk_sys);
        wr(`OFS_IRQ_FLAGS, 8'he0);
        wr(`OFS_IRQ_ENABLE, 8'he0);
        reqchk(3'h0);
        ext_pin_source_inst.pulse(2, 1'b0, 6);
        repeat (8) @(posedge clk_sys);
        rdc(`OFS_IRQ_FLAGS, 8'h20);
        reqchk(3'h4);
    end
    wr(`OFS_CONTROL_STATUS, 8'hff);
    rdc(`OFS_CONTROL_STATUS, 8'hc0);
    chk({31'h0, debug_port_disable}, 32'h1);
    wr(`OFS_IRQ_ENABLE, 8'hff);
    rdc(`OFS_IRQ_ENABLE, 8'he0);
    wr(`OFS_SENSE_CONTROL, 8'ha5);
    rdc(`OFS_SENSE_CONTROL, 8'ha5);
    wr(5'h14, 8'hff);
    rdc(5'h14, 8'h00);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    wr(`OFS_IRQ_FLAGS, 8'he0);
    sleep_deep <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sleep_deep <= 1'b0;
    // buffer coming back with rising polarity sets pin two
    repeat (4) @(posedge clk_sys);
    rdc(`OFS_IRQ_FLAGS, 8'h20);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++)
        rdc(5'(a * 4), 8'h00);
    results();
end
endmodule // external_pin_interrupt_unit_tb_top
